// [src/ffl_regs.vh]
`ifndef FFL_REGS_VH
`define FFL_REGS_VH
// Operation
// - latency counts edges from the operation edge; zero means that same edge
// - single clock: write moves full, nearly full, ack, overflow at once; prog full later
// - single clock: read moves empty, nearly empty, valid, underflow, count at once
// - single clock: read moves full and nearly full at once, prog full one later
// - write acknowledge and overflow change only on write attempts
// - single clock, no or one output register: write reaches empty after 2, near/prog after 1
// - single clock, both output registers: write reaches empty after 3, near/prog empty after 2
// - underflow changes only on read attempts; valid does too in dual clock, in single clock it follows not empty
// - dual clock: write moves full side at once; prog full, write count one later
// - dual clock: read moves empty side at once; prog empty, read count one later
// - dual clock: read reaches full, nearly full, write count after 1 + N+2
// - dual clock: read reaches prog full after 1 + N+3 write clocks
// - dual clock: write reaches empty, nearly empty, read count after 1 + N+2
// - dual clock: write reaches prog empty after 1 + N+3 read clocks
// - pointer crossing uses N synchroniser stages, two by default
`define FFL_ADDR_W       8
`define FFL_ADDR_PF_THR  8'h00
`define FFL_ADDR_PE_THR  8'h04
`define FFL_ADDR_STATUS  8'h08
`define FFL_ADDR_COUNT   8'h0C
`define FFL_THR_W        16
`define FFL_PF_THR_RST   16'h000C
`define FFL_PE_THR_RST   16'h0004
`define FFL_ST_FULL      0
`define FFL_ST_NFULL     1
`define FFL_ST_PFULL     2
`define FFL_ST_EMPTY     3
`define FFL_ST_NEMPTY    4
`define FFL_ST_PEMPTY    5
`define FFL_ST_W         6
`define FFL_NEAR_GAP     1
`define FFL_SYNC_N       2
`endif

// [src/ffl_sync.v]
`timescale 1ns/1ps
`include "ffl_regs.vh"
module ffl_sync
#(
   parameter WIDTH  = 5,
   parameter STAGES = `FFL_SYNC_N
)
(
   input  wire             clk_sys,
   input  wire             rstn,
   input  wire [WIDTH-1:0] d,
   output wire [WIDTH-1:0] q
);

   reg [WIDTH-1:0] stage_q [0:STAGES-1];

   genvar g;
   generate
      for (g = 0; g < STAGES; g = g + 1)
      begin : g_stage
         always @(posedge clk_sys or negedge rstn)
         begin
            if (!rstn)
               stage_q[g] <= {WIDTH{1'b0}};
            else if (g == 0)
               stage_q[g] <= d;
            else
               stage_q[g] <= stage_q[(g == 0) ? 0 : g-1];
         end
      end
   endgenerate

   assign q = stage_q[STAGES-1];

endmodule // ffl_sync

// [src/ffl_top.v]
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "ffl_regs.vh"
module ffl_top
#(
   parameter DW          = 8,
   parameter AW          = 4,
   parameter SYNC_STAGES = `FFL_SYNC_N,
   parameter DUAL_MODE   = 0,
   parameter OUT_REGS    = 0
)
(
   input  wire                   clk_sys,
   input  wire                   rstn,
   input  wire                   wr_en,
   input  wire [DW-1:0]          wr_data,
   input  wire                   rd_en,
   output reg  [DW-1:0]          rd_data_q,
   output reg                    valid_q,
   output reg                    underflow_q,
   output reg                    full_q,
   output reg                    nearly_full_flag_q,
   output reg                    programmable_full_flag_q,
   output reg                    write_acknowledge_q,
   output reg                    overflow_q,
   output reg                    empty_q,
   output reg                    nearly_empty_flag_q,
   output reg                    programmable_empty_flag_q,
   output reg  [AW:0]            occupancy_count_q,
   output reg  [AW:0]            write_side_occupancy_q,
   output reg  [AW:0]            read_side_occupancy_q,
   input  wire [`FFL_ADDR_W-1:0] bus_addr,
   input  wire [31:0]            bus_wdata,
   input  wire                   bus_wr,
   input  wire                   bus_rd,
   output reg  [31:0]            bus_rdata_q
);

   localparam PW    = AW + 1;
   localparam DEPTH = 1 << AW;
   localparam LAT   = (OUT_REGS == 2) ? 2 : 1;
   localparam [PW-1:0] NF_LEVEL = DEPTH - `FFL_NEAR_GAP;
   localparam [PW-1:0] NE_LEVEL = `FFL_NEAR_GAP;
   localparam [PW-1:0] PTR_ONE  = 1;

   function [PW-1:0] bin2gray;
      input [PW-1:0] b;
      begin
         bin2gray = b ^ (b >> 1);
      end
   endfunction

   function [PW-1:0] gray2bin;
      input [PW-1:0] g;
      integer i;
      begin
         gray2bin[PW-1] = g[PW-1];
         for (i = PW - 2; i >= 0; i = i - 1)
            gray2bin[i] = gray2bin[i+1] ^ g[i];
      end
   endfunction

   reg  [DW-1:0]          mem_q [0:DEPTH-1];
   reg  [PW-1:0]          wptr_q;
   reg  [PW-1:0]          rptr_q;
   reg  [PW-1:0]          wpd0_q;
   reg  [PW-1:0]          wpd1_q;
   reg  [PW-1:0]          wgray_q;
   reg  [PW-1:0]          rgray_q;
   reg  [PW-1:0]          wptr_r_q;
   reg  [PW-1:0]          wptr_r2_q;
   reg  [PW-1:0]          rptr_w_q;
   reg  [PW-1:0]          rptr_w2_q;
   reg  [`FFL_THR_W-1:0]  pf_thr_q;
   reg  [`FFL_THR_W-1:0]  pe_thr_q;

   wire                   wr_fire;
   wire                   rd_fire;
   wire [PW-1:0]          wptr_d;
   wire [PW-1:0]          rptr_d;
   wire [PW-1:0]          wsync;
   wire [PW-1:0]          rsync;
   wire [PW-1:0]          rp_f;
   wire [PW-1:0]          rp_pf;
   wire [PW-1:0]          wp_e;
   wire [PW-1:0]          wp_ne;
   wire [PW-1:0]          wp_pe;
   wire [PW-1:0]          wcnt_f;
   wire [PW-1:0]          wcnt_pf;
   wire [PW-1:0]          rcnt_e;
   wire [PW-1:0]          rcnt_ne;
   wire [PW-1:0]          rcnt_pe;
   wire [PW-1:0]          occ_d;
   wire [`FFL_ST_W-1:0]   status;

   // a refused attempt moves no pointer
   assign wr_fire = wr_en & ~full_q;
   assign rd_fire = rd_en & ~empty_q;
   assign wptr_d  = wr_fire ? wptr_q + PTR_ONE : wptr_q;
   assign rptr_d  = rd_fire ? rptr_q + PTR_ONE : rptr_q;

   // pointer crossing through N stages
   ffl_sync
   #(
      .WIDTH  (PW),
      .STAGES (SYNC_STAGES)
   )
   u_wsync
   (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .d       (wgray_q),
      .q       (wsync)
   );

   ffl_sync
   #(
      .WIDTH  (PW),
      .STAGES (SYNC_STAGES)
   )
   u_rsync
   (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .d       (rgray_q),
      .q       (rsync)
   );

   // pointer views seen by each flag
   assign rp_f  = DUAL_MODE ? rptr_w_q : rptr_d;
   assign rp_pf = DUAL_MODE ? rptr_w2_q : rptr_q;
   assign wp_ne = DUAL_MODE ? wptr_r_q : ((LAT == 1) ? wptr_q : wpd0_q);
   assign wp_e  = DUAL_MODE ? wptr_r_q : ((LAT == 1) ? wpd0_q : wpd1_q);
   assign wp_pe = DUAL_MODE ? wptr_r2_q : wp_ne;

   assign wcnt_f  = wptr_d - rp_f;
   assign wcnt_pf = wptr_q - rp_pf;
   assign rcnt_e  = wp_e - rptr_d;
   assign rcnt_ne = wp_ne - rptr_d;
   assign rcnt_pe = wp_pe - rptr_q;
   assign occ_d   = wptr_d - rptr_d;

   always @(posedge clk_sys)
   begin
      if (wr_fire)
         mem_q[wptr_q[AW-1:0]] <= wr_data;
   end

   // pointers and their delayed and crossed copies
   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         wptr_q    <= {PW{1'b0}};
         rptr_q    <= {PW{1'b0}};
         wpd0_q    <= {PW{1'b0}};
         wpd1_q    <= {PW{1'b0}};
         wgray_q   <= {PW{1'b0}};
         rgray_q   <= {PW{1'b0}};
         wptr_r_q  <= {PW{1'b0}};
         wptr_r2_q <= {PW{1'b0}};
         rptr_w_q  <= {PW{1'b0}};
         rptr_w2_q <= {PW{1'b0}};
      end
      else
      begin
         wptr_q    <= wptr_d;
         rptr_q    <= rptr_d;
         wpd0_q    <= wptr_q;
         wpd1_q    <= wpd0_q;
         wgray_q   <= bin2gray(wptr_q);
         rgray_q   <= bin2gray(rptr_q);
         wptr_r_q  <= gray2bin(wsync);
         wptr_r2_q <= wptr_r_q;
         rptr_w_q  <= gray2bin(rsync);
         rptr_w2_q <= rptr_w_q;
      end
   end

   // write side flags
   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         full_q                   <= 1'b0;
         nearly_full_flag_q       <= 1'b0;
         programmable_full_flag_q <= 1'b0;
         write_acknowledge_q      <= 1'b0;
         overflow_q               <= 1'b0;
         write_side_occupancy_q   <= {PW{1'b0}};
      end
      else
      begin
         full_q                   <= wcnt_f[AW];
         nearly_full_flag_q       <= (wcnt_f >= NF_LEVEL);
         programmable_full_flag_q <= ({{(`FFL_THR_W-PW){1'b0}}, wcnt_pf} >= pf_thr_q);
         write_acknowledge_q      <= wr_fire;
         overflow_q               <= wr_en & full_q;
         if (DUAL_MODE)
            write_side_occupancy_q <= wptr_q - rptr_w_q;
         else
            write_side_occupancy_q <= occ_d;
      end
   end

   // read side flags
   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         empty_q                   <= 1'b1;
         nearly_empty_flag_q       <= 1'b1;
         programmable_empty_flag_q <= 1'b1;
         valid_q                   <= 1'b0;
         underflow_q               <= 1'b0;
         occupancy_count_q         <= {PW{1'b0}};
         read_side_occupancy_q     <= {PW{1'b0}};
      end
      else
      begin
         empty_q                   <= (rcnt_e == {PW{1'b0}});
         nearly_empty_flag_q       <= (rcnt_ne <= NE_LEVEL);
         programmable_empty_flag_q <= ({{(`FFL_THR_W-PW){1'b0}}, rcnt_pe} <= pe_thr_q);
         underflow_q               <= rd_en & empty_q;
         occupancy_count_q         <= occ_d;
         if (DUAL_MODE)
         begin
            valid_q               <= rd_fire;
            read_side_occupancy_q <= wptr_r_q - rptr_q;
         end
         else
         begin
            valid_q               <= (rcnt_e != {PW{1'b0}});
            read_side_occupancy_q <= occ_d;
         end
      end
   end

   // read data: fall-through presents head, standard loads on read
   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         rd_data_q <= {DW{1'b0}};
      else if (!DUAL_MODE)
         rd_data_q <= mem_q[rptr_d[AW-1:0]];
      else if (rd_fire)
         rd_data_q <= mem_q[rptr_q[AW-1:0]];
   end

   assign status[`FFL_ST_FULL]   = full_q;
   assign status[`FFL_ST_NFULL]  = nearly_full_flag_q;
   assign status[`FFL_ST_PFULL]  = programmable_full_flag_q;
   assign status[`FFL_ST_EMPTY]  = empty_q;
   assign status[`FFL_ST_NEMPTY] = nearly_empty_flag_q;
   assign status[`FFL_ST_PEMPTY] = programmable_empty_flag_q;

   // threshold registers
   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         pf_thr_q <= `FFL_PF_THR_RST;
         pe_thr_q <= `FFL_PE_THR_RST;
      end
      else if (bus_wr)
      begin
         if (bus_addr == `FFL_ADDR_PF_THR)
            pf_thr_q <= bus_wdata[`FFL_THR_W-1:0];
         else if (bus_addr == `FFL_ADDR_PE_THR)
            pe_thr_q <= bus_wdata[`FFL_THR_W-1:0];
      end
   end

   // read data stands only in the cycle after the strobe
   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         bus_rdata_q <= 32'h00000000;
      else if (!bus_rd)
         bus_rdata_q <= 32'h00000000;
      else if (bus_addr == `FFL_ADDR_PF_THR)
         bus_rdata_q <= {{(32-`FFL_THR_W){1'b0}}, pf_thr_q};
      else if (bus_addr == `FFL_ADDR_PE_THR)
         bus_rdata_q <= {{(32-`FFL_THR_W){1'b0}}, pe_thr_q};
      else if (bus_addr == `FFL_ADDR_STATUS)
         bus_rdata_q <= {{(32-`FFL_ST_W){1'b0}}, status};
      else if (bus_addr == `FFL_ADDR_COUNT)
         bus_rdata_q <= {{(32-PW){1'b0}}, occupancy_count_q};
      else
         bus_rdata_q <= 32'h00000000;
   end

endmodule // ffl_top

// [verif/ffl_peer.sv]
`timescale 1ns/1ps
module ffl_peer
(
   input  wire       clk_sys,
   input  wire       rstn,
   input  wire       push,
   input  wire       pop,
   output wire       wr_en,
   output wire [7:0] wr_data,
   output wire       rd_en
);
   reg [7:0] seq_q;
   assign wr_en = push;
   assign rd_en = pop;
   // idle data is inverted so a stale word never looks valid
   assign wr_data = push ? seq_q : ~seq_q;
   always @(posedge clk_sys or negedge rstn)
      if (!rstn)
         seq_q <= 8'hA0;
      else if (push)
         seq_q <= seq_q + 8'h01;
endmodule // ffl_peer

// [verif/ffl_chk_assertions.sv]
`timescale 1ns/1ps
`include "ffl_regs.vh"
module ffl_chk
#(
   parameter DW = 8,
   parameter AW        = 4,
   parameter DUAL_MODE = 0
)
(
   input wire        clk_sys,
   input wire        rstn,
   input wire        wr_en,
   input wire        rd_en,
   input wire        full_q,
   input wire        nearly_full_flag_q,
   input wire        programmable_full_flag_q,
   input wire        write_acknowledge_q,
   input wire        overflow_q,
   input wire        empty_q,
   input wire        programmable_empty_flag_q,
   input wire        valid_q,
   input wire        underflow_q,
   input wire [AW:0] occupancy_count_q
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_ack_taken: assert property (wr_en && !full_q |=> write_acknowledge_q && !overflow_q)
      else $error("ack missing");
   a_ovf_refused: assert property (wr_en && full_q |=> overflow_q && !write_acknowledge_q)
      else $error("overflow missing");
   a_wr_hs_quiet: assert property (!wr_en |=> !write_acknowledge_q && !overflow_q)
      else $error("write handshake moved");
   a_uf_refused: assert property (rd_en && empty_q |=> underflow_q)
      else $error("underflow missing");
   a_rd_hs_quiet: assert property (!rd_en |=> !underflow_q)
      else $error("underflow moved");
   a_count_up: assert property (wr_en && !full_q && !(rd_en && !empty_q)
      |=> occupancy_count_q == $past(occupancy_count_q) + 1'b1) else $error("count up");
   a_count_down: assert property (rd_en && !empty_q && !(wr_en && !full_q)
      |=> occupancy_count_q == $past(occupancy_count_q) - 1'b1) else $error("count down");
   // same-clock flag timing only holds in fall-through mode
   a_full_flags: assert property (DUAL_MODE != 0 || (full_q == (occupancy_count_q == (1 << AW))
      && nearly_full_flag_q == (occupancy_count_q >= (1 << AW) - 1))) else $error("full flags");
   a_pfull_lag: assert property (DUAL_MODE != 0 || programmable_full_flag_q ==
      ($past(occupancy_count_q) >= `FFL_PF_THR_RST)) else $error("prog full");
   a_pempty_lag: assert property (DUAL_MODE != 0 || programmable_empty_flag_q ==
      ($past(occupancy_count_q) <= `FFL_PE_THR_RST)) else $error("prog empty");
   a_empty_wr: assert property (DUAL_MODE == 0 && occupancy_count_q == 0 && wr_en
      |=> empty_q ##1 empty_q ##1 !empty_q) else $error("empty latency");
   a_valid_level: assert property (DUAL_MODE != 0 || valid_q == !empty_q)
      else $error("valid level");
endmodule // ffl_chk
bind ffl_top ffl_chk #(.DW(DW), .AW(AW), .DUAL_MODE(DUAL_MODE)) i_chk (.clk_sys, .rstn, .wr_en, .rd_en, .full_q,
   .nearly_full_flag_q, .programmable_full_flag_q, .write_acknowledge_q, .overflow_q, .empty_q,
   .programmable_empty_flag_q, .valid_q, .underflow_q, .occupancy_count_q);

// [verif/ffl_top_tb_top.sv]
`timescale 1ns/1ps
`include "ffl_regs.vh"
module ffl_top_tb_top;
   reg         clk_sys = 1'b0;
   reg         rstn = 1'b0;
   reg         push = 1'b0;
   reg         pop = 1'b0;
   reg  [7:0]  bus_addr = 8'h00;
   reg  [31:0] bus_wdata = 32'h0;
   reg         bus_wr = 1'b0;
   reg         bus_rd = 1'b0;
   wire        wr_en, rd_en, valid_q, underflow_q, full_q, nearly_full_flag_q, programmable_full_flag_q;
   wire        write_acknowledge_q, overflow_q, empty_q, nearly_empty_flag_q, programmable_empty_flag_q;
   wire [7:0]  wr_data, rd_data_q;
   wire [4:0]  occupancy_count_q, wocc_q, rocc_q;
   reg         push2 = 1'b0;
   reg         pop2 = 1'b0;
   wire        wr_en2, rd_en2, valid2_q, ack2_q, empty2_q;
   wire [7:0]  wr_data2, rdata2_q;
   wire [4:0]  wocc2_q, rocc2_q;
   wire [31:0] bus_rdata_q;
   integer     fail_count = 0;
   integer     cmp_count = 0;
   integer     i;
   ffl_peer i_peer (.clk_sys, .rstn, .push, .pop, .wr_en, .wr_data, .rd_en);
   ffl_top i_dut (.clk_sys, .rstn, .wr_en, .wr_data, .rd_en, .rd_data_q, .valid_q, .underflow_q, .full_q,
      .nearly_full_flag_q, .programmable_full_flag_q, .write_acknowledge_q, .overflow_q, .empty_q,
      .nearly_empty_flag_q, .programmable_empty_flag_q, .occupancy_count_q, .write_side_occupancy_q(wocc_q),
      .read_side_occupancy_q(rocc_q), .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata_q);
   // second copy in crossed-pointer mode
   ffl_peer i_peer2 (.clk_sys, .rstn, .push(push2), .pop(pop2), .wr_en(wr_en2), .wr_data(wr_data2),
      .rd_en(rd_en2));
   ffl_top #(.DUAL_MODE(1)) i_dut2 (.clk_sys, .rstn, .wr_en(wr_en2), .wr_data(wr_data2), .rd_en(rd_en2),
      .rd_data_q(rdata2_q), .valid_q(valid2_q), .underflow_q(), .full_q(), .nearly_full_flag_q(),
      .programmable_full_flag_q(), .write_acknowledge_q(ack2_q), .overflow_q(), .empty_q(empty2_q),
      .nearly_empty_flag_q(), .programmable_empty_flag_q(), .occupancy_count_q(),
      .write_side_occupancy_q(wocc2_q), .read_side_occupancy_q(rocc2_q), .bus_addr, .bus_wdata, .bus_wr,
      .bus_rd, .bus_rdata_q());
   always #5 clk_sys = ~clk_sys;
   task chk(input string nm, input [31:0] exp, input [31:0] got);
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
         fail_count = fail_count + 1;
         $display("MISMATCH %0s expected %h seen %h", nm, exp, got);
      end
   endtask
   task bw(input [7:0] a, input [31:0] d);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
   endtask
   task br(input [7:0] a, input [31:0] e);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk_sys);
      bus_rd <= 1'b0;
      #1 chk("bus_rdata", e, bus_rdata_q);
   endtask
   task t_regs;
      br(`FFL_ADDR_PF_THR, 32'h0000000C);
      br(`FFL_ADDR_PE_THR, 32'h00000004);
      br(`FFL_ADDR_STATUS, 32'h00000038);
      br(8'h10, 32'h00000000);
      bw(`FFL_ADDR_PF_THR, 32'h0000000A);
      br(`FFL_ADDR_PF_THR, 32'h0000000A);
      bw(`FFL_ADDR_PF_THR, 32'h0000000C);
      $display("test regs done");
   endtask
   task t_fill;
      @(posedge clk_sys);
      push <= 1'b1;
      repeat (17) @(posedge clk_sys);
      push <= 1'b0;
      #1 chk("overflow", 1, overflow_q);
      chk("ack", 0, write_acknowledge_q);
      chk("full", 1, full_q);
      chk("count", 16, occupancy_count_q);
      chk("wocc", 16, wocc_q);
      chk("rocc", 16, rocc_q);
      chk("pfull", 1, programmable_full_flag_q);
      chk("nempty", 0, nearly_empty_flag_q);
      @(posedge clk_sys);
      #1 chk("overflow", 0, overflow_q);
      br(`FFL_ADDR_STATUS, 32'h00000007);
      br(`FFL_ADDR_COUNT, 32'h00000010);
      $display("test fill done");
   endtask
   task t_drain;
      @(posedge clk_sys);
      pop <= 1'b1;
      #1 chk("head", 8'hA0, rd_data_q);
      for (i = 1; i < 17; i = i + 1)
      begin
         @(posedge clk_sys);
         #1 if (i < 16) chk("rd_data", 8'hA0 + i, rd_data_q);
         if (i == 1) chk("full", 0, full_q);
      end
      chk("empty", 1, empty_q);
      chk("count", 0, occupancy_count_q);
      chk("nempty", 1, nearly_empty_flag_q);
      @(posedge clk_sys);
      pop <= 1'b0;
      #1 chk("underflow", 1, underflow_q);
      $display("test drain done");
   endtask
   task t_lat;
      @(posedge clk_sys);
      push <= 1'b1;
      @(posedge clk_sys);
      push <= 1'b0;
      #1 chk("ack", 1, write_acknowledge_q);
      chk("count", 1, occupancy_count_q);
      chk("empty", 1, empty_q);
      @(posedge clk_sys);
      #1 chk("empty", 1, empty_q);
      @(posedge clk_sys);
      #1 chk("empty", 0, empty_q);
      chk("valid", 1, valid_q);
      chk("rd_data", 8'hB1, rd_data_q);
      @(posedge clk_sys);
      pop <= 1'b1;
      @(posedge clk_sys);
      pop <= 1'b0;
      #1 chk("empty", 1, empty_q);
      chk("ack", 0, write_acknowledge_q);
      $display("test latency done");
   endtask
   task t_dual;
      @(posedge clk_sys);
      push2 <= 1'b1;
      @(posedge clk_sys);
      push2 <= 1'b0;
      #1 chk("ack2", 1, ack2_q);
      chk("wocc2", 0, wocc2_q);
      @(posedge clk_sys);
      #1 chk("wocc2", 1, wocc2_q);
      repeat (3) @(posedge clk_sys);
      #1 chk("empty2", 1, empty2_q);
      chk("rocc2", 0, rocc2_q);
      @(posedge clk_sys);
      #1 chk("empty2", 0, empty2_q);
      chk("rocc2", 1, rocc2_q);
      @(posedge clk_sys);
      pop2 <= 1'b1;
      @(posedge clk_sys);
      pop2 <= 1'b0;
      #1 chk("valid2", 1, valid2_q);
      chk("rdata2", 8'hA0, rdata2_q);
      chk("empty2", 1, empty2_q);
      repeat (4) @(posedge clk_sys);
      #1 chk("wocc2", 1, wocc2_q);
      @(posedge clk_sys);
      #1 chk("wocc2", 0, wocc2_q);
      $display("test dual done");
   endtask
   task stop_test;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      t_regs;
      t_fill;
      t_drain;
      t_lat;
      t_dual;
      stop_test;
   end
   // whole run is well under 200 cycles
   initial
   begin
      repeat (2000) @(posedge clk_sys);
      fail_count = fail_count + 1;
      stop_test;
   end
endmodule // ffl_top_tb_top
